// file: ctoe_pkg.sv
package ctoe_pkg;
    localparam int NUM_OBJ = 4;
    localparam int NUM_MAP = 4;
    localparam int NUM_WORDS = 16;
    localparam int CLK_MHZ = 250;
    localparam int INH_UNIT_US = 100;
    localparam int EVT_UNIT_US = 1000;
    localparam int INH_UNIT_CYC = INH_UNIT_US * CLK_MHZ;
    localparam int EVT_UNIT_CYC = EVT_UNIT_US * CLK_MHZ;
    localparam logic [15:0] EVT_MAX = 16'h0CCC;
    localparam logic [7:0] TT_SYNC_MAX = 8'hF0;
    localparam logic [7:0] TT_RTR_SYNC = 8'hFC;
    localparam logic [7:0] TT_RTR_ONLY = 8'hFD;
    localparam logic [7:0] TT_EVENT = 8'hFE;
    localparam logic [7:0] TT_RESET = 8'hFE;
    localparam logic [7:0] MAP_CNT_RESET = 8'h04;
    localparam logic [15:0] MAP_BASE_INDEX = 16'h3D22;
    localparam logic [15:0] MAP_RESET_LOW = 16'h0010;
    localparam logic [10:0] ID_BASE [4] = '{11'h180, 11'h280, 11'h380, 11'h480};
    localparam int COB_DIS_BIT = 31;
    localparam logic [31:0] COB_WR_MASK = 32'h800007FF;
    localparam int ADDR_W = 9;
    localparam logic [3:0] SUB_COB = 4'h0;
    localparam logic [3:0] SUB_TYPE = 4'h1;
    localparam logic [3:0] SUB_INH = 4'h2;
    localparam logic [3:0] SUB_EVT = 4'h3;
    localparam logic [3:0] SUB_CNT = 4'h4;
    localparam logic [3:0] SUB_MAP1 = 4'h5;
    localparam logic [8:0] STATUS_ADDR = 9'h100;
    localparam int FIFO_DEPTH = 8;
    localparam int FRAME_W = 11 + 4 + 64;
endpackage

// file: ctoe_engine.sv
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
// frame buffer between the object engine and the controller
module ctoe_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    logic [W-1:0] mem [D];
    logic [$clog2(D)-1:0] wr_ptr;
    logic [$clog2(D)-1:0] rd_ptr;
    logic push;
    logic pop;

    // honest full and empty
    assign in_ready = (level != D[$clog2(D):0]);
    assign out_valid = (level != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // storage
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // pointers and fill level
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                level <= level + 1'b1;
            else if (pop && !push)
                level <= level - 1'b1;
        end
    end
endmodule

module ctoe_engine #(
    parameter int EVT_CYC = ctoe_pkg::EVT_UNIT_CYC,
    parameter int INH_CYC = ctoe_pkg::INH_UNIT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [6:0] node_id,
    input wire logic nmt_operational,
    input wire logic sync_pulse,
    input wire logic rtr_valid,
    input wire logic [10:0] rtr_id,
    input wire logic [255:0] output_word_marker,
    input wire logic [8:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [10:0] tx_id,
    output logic [3:0] tx_dlc,
    output logic [63:0] tx_data
);
    logic [31:0] cob [4];
    logic cob_set [4];
    logic [7:0] ttype [4];
    logic [15:0] inhibit [4];
    logic [15:0] evt [4];
    logic [7:0] map_cnt [4];
    logic [31:0] map_e [4][4];
    logic [31:0] cob_eff [4];
    logic [7:0] sync_cnt [4];
    logic [15:0] evt_cnt [4];
    logic [16:0] inh_cnt [4];
    logic [3:0] pend;
    logic [3:0] en;
    logic [3:0] elig;
    logic [3:0] trig;
    logic [67:0] latch [4];
    logic [67:0] live [4];
    logic [17:0] evt_pre;
    logic [14:0] inh_pre;
    logic evt_tick;
    logic inh_tick;
    logic [1:0] sel;
    logic push;
    logic fifo_ready;
    logic [78:0] fifo_in;
    logic [3:0] fifo_level;
    logic [1:0] wobj;
    logic [3:0] wsub;
    logic obj_acc;
    logic [7:0] rej_cnt;
    logic [8:0] new_bits;

    // packs up to four mapped words; entries past the count add nothing
    function automatic logic [67:0] pack(input logic [31:0] m [4],
        input logic [7:0] n, input logic [255:0] w);
        logic [63:0] d;
        logic [6:0] pos;
        logic [15:0] idx;
        logic [15:0] v;
        d = '0;
        pos = '0;
        for (int i = 0; i < 4; i++)
        begin
            idx = m[i][31:16] - ctoe_pkg::MAP_BASE_INDEX;
            v = (idx < 16'h0010) ? w[idx[3:0]*16 +: 16] : 16'h0000;
            if (m[i][7:0] == 8'h08)
                v = {8'h00, v[7:0]};
            if (i < n && pos < 7'h40)
            begin
                d = d | (64'(v) << pos);
                pos = pos + 7'(m[i][7:0]);
            end
        end
        return {4'(pos[6:3]), d};
    endfunction

    // total length of a candidate map with n entries
    function automatic logic [8:0] map_bits(input logic [31:0] m [4],
        input logic [7:0] n);
        logic [8:0] s;
        s = '0;
        for (int i = 0; i < 4; i++)
            if (i < n)
                s = s + 9'(m[i][7:0]);
        return s;
    endfunction

    // register address decode: object, slot, object space
    assign wobj = reg_addr[7:6];
    assign wsub = reg_addr[5:2];
    assign obj_acc = !reg_addr[8];
    assign new_bits = map_bits(map_e[wobj], reg_wdata[7:0]);

    // effective identifier and gating per object
    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            cob_eff[k] = cob_set[k] ? cob[k]
                : {21'h0, ctoe_pkg::ID_BASE[k] + {4'h0, node_id}};
            en[k] = !cob_eff[k][ctoe_pkg::COB_DIS_BIT]
                && map_cnt[k] != 8'h00 && nmt_operational;
            elig[k] = pend[k] && en[k] && inh_cnt[k] == 17'h0;
            live[k] = pack(map_e[k], map_cnt[k], output_word_marker);
        end
    end

    // shared time bases for event and inhibit timers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_pre <= '0;
            inh_pre <= '0;
        end
        else
        begin
            evt_pre <= evt_tick ? '0 : evt_pre + 1'b1;
            inh_pre <= inh_tick ? '0 : inh_pre + 1'b1;
        end
    end
    assign evt_tick = (evt_pre == 18'(EVT_CYC - 1));
    assign inh_tick = (inh_pre == 15'(INH_CYC - 1));

    // lowest numbered eligible object wins the buffer
    always_comb
    begin
        sel = 2'h0;
        for (int k = 3; k >= 0; k--)
            if (elig[k])
                sel = 2'(k);
    end
    assign push = (elig != 4'h0) && fifo_ready;
    assign fifo_in = {cob_eff[sel][10:0],
        ttype[sel] == ctoe_pkg::TT_RTR_SYNC ? latch[sel] : live[sel]};

    // trigger sources per transmission type
    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            trig[k] = 1'b0;
            if (sync_pulse && ttype[k] != 8'h00
                && ttype[k] <= ctoe_pkg::TT_SYNC_MAX
                && sync_cnt[k] + 8'h01 >= ttype[k])
                trig[k] = 1'b1;
            if (rtr_valid && rtr_id == cob_eff[k][10:0]
                && (ttype[k] == ctoe_pkg::TT_RTR_SYNC
                || ttype[k] == ctoe_pkg::TT_RTR_ONLY))
                trig[k] = 1'b1;
            if (ttype[k] >= ctoe_pkg::TT_EVENT && evt[k] != 16'h0
                && evt_tick && evt_cnt[k] <= 16'h0001)
                trig[k] = 1'b1;
        end
    end

    // sync, event and inhibit counters, pending flags, sync latch
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend <= '0;
            for (int k = 0; k < 4; k++)
            begin
                sync_cnt[k] <= '0;
                evt_cnt[k] <= '0;
                inh_cnt[k] <= '0;
                latch[k] <= '0;
            end
        end
        else
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (sync_pulse)
                    sync_cnt[k] <= trig[k] ? 8'h00 : sync_cnt[k] + 8'h01;
                if (sync_pulse && ttype[k] == ctoe_pkg::TT_RTR_SYNC)
                    latch[k] <= live[k];
                if (evt_tick)
                    evt_cnt[k] <= (evt_cnt[k] <= 16'h0001) ? evt[k]
                        : evt_cnt[k] - 16'h0001;
                if (push && sel == 2'(k))
                    inh_cnt[k] <= (inhibit[k] == 16'h0) ? 17'h0
                        : {1'b0, inhibit[k]} + 17'h1;
                else if (inh_tick && inh_cnt[k] != 17'h0)
                    inh_cnt[k] <= inh_cnt[k] - 17'h1;
                // a trigger in the send cycle is kept; disabled objects drop
                if (!en[k])
                    pend[k] <= 1'b0;
                else if (trig[k])
                    pend[k] <= 1'b1;
                else if (push && sel == 2'(k))
                    pend[k] <= 1'b0;
            end
        end
    end

    // configuration writes
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rej_cnt <= '0;
            for (int k = 0; k < 4; k++)
            begin
                cob[k] <= '0;
                cob_set[k] <= 1'b0;
                ttype[k] <= ctoe_pkg::TT_RESET;
                inhibit[k] <= '0;
                evt[k] <= '0;
                map_cnt[k] <= ctoe_pkg::MAP_CNT_RESET;
                for (int j = 0; j < 4; j++)
                    map_e[k][j] <= {ctoe_pkg::MAP_BASE_INDEX + 16'(k * 4 + j),
                        ctoe_pkg::MAP_RESET_LOW};
            end
        end
        else if (reg_wr && obj_acc)
        begin
            unique case (wsub)
                ctoe_pkg::SUB_COB:
                begin
                    cob[wobj] <= reg_wdata & ctoe_pkg::COB_WR_MASK;
                    cob_set[wobj] <= 1'b1;
                end
                ctoe_pkg::SUB_TYPE: ttype[wobj] <= reg_wdata[7:0];
                ctoe_pkg::SUB_INH: inhibit[wobj] <= reg_wdata[15:0];
                ctoe_pkg::SUB_EVT:
                    if (reg_wdata[15:0] <= ctoe_pkg::EVT_MAX)
                        evt[wobj] <= reg_wdata[15:0];
                    else
                        rej_cnt <= rej_cnt + 8'h01;
                ctoe_pkg::SUB_CNT:
                    if (reg_wdata[7:0] <= 8'h04 && new_bits <= 9'h040)
                        map_cnt[wobj] <= reg_wdata[7:0];
                    else
                        rej_cnt <= rej_cnt + 8'h01;
                4'h5, 4'h6, 4'h7, 4'h8:
                    if (map_cnt[wobj] == 8'h00)
                        map_e[wobj][2'(wsub - ctoe_pkg::SUB_MAP1)] <= reg_wdata;
                    else
                        rej_cnt <= rej_cnt + 8'h01;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            reg_rdata <= '0;
            if (reg_addr == ctoe_pkg::STATUS_ADDR)
                reg_rdata <= {16'h0, rej_cnt, pend, fifo_level};
            else if (obj_acc)
                unique case (wsub)
                    ctoe_pkg::SUB_COB: reg_rdata <= cob_eff[wobj];
                    ctoe_pkg::SUB_TYPE: reg_rdata <= {24'h0, ttype[wobj]};
                    ctoe_pkg::SUB_INH: reg_rdata <= {16'h0, inhibit[wobj]};
                    ctoe_pkg::SUB_EVT: reg_rdata <= {16'h0, evt[wobj]};
                    ctoe_pkg::SUB_CNT: reg_rdata <= {24'h0, map_cnt[wobj]};
                    4'h5, 4'h6, 4'h7, 4'h8:
                        reg_rdata <= map_e[wobj][2'(wsub - ctoe_pkg::SUB_MAP1)];
                    default: reg_rdata <= '0;
                endcase
        end
    end

    // outgoing frame buffer
    ctoe_fifo #(
        .W(ctoe_pkg::FRAME_W),
        .D(ctoe_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(elig != 4'h0),
        .in_ready(fifo_ready),
        .in_data(fifo_in),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data({tx_id, tx_dlc, tx_data}),
        .level(fifo_level)
    );

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_no_send_offline: assert property (!nmt_operational |-> !push)
        else $error("frame queued outside operational state");
    a_frame_id_match: assert property (push |->
        fifo_in[78:68] == cob_eff[sel][10:0])
        else $error("queued identifier differs from record");
    a_dlc_bound: assert property (push |-> fifo_in[67:64] <= 4'h8)
        else $error("frame longer than eight bytes");
    a_inhibit_gap: assert property (push && sel == 2'h3
        && inhibit[3] != 16'h0000 |=> !(push && sel == 2'h3)
        && inh_cnt[3] == {1'b0, $past(inhibit[3])} + 17'h00001)
        else $error("inhibit time not started after send");
    a_map_locked: assert property (reg_wr && obj_acc
        && wsub == ctoe_pkg::SUB_MAP1 && wobj == 2'h1
        && map_cnt[1] != 8'h00 |=> $stable(map_e[1][0]))
        else $error("map entry changed while enabled");
    a_count_range: assert property (map_cnt[1] <= 8'h04
        && map_bits(map_e[1], map_cnt[1]) <= 9'h040)
        else $error("map count or length out of range");
    a_rtr_pends: assert property (rtr_valid && en[1]
        && rtr_id == cob_eff[1][10:0] && ttype[1] == ctoe_pkg::TT_RTR_ONLY
        |=> pend[1])
        else $error("remote request did not arm object");
    a_type0_silent: assert property (ttype[0] == 8'h00
        && !rtr_valid |-> !trig[0])
        else $error("type zero object triggered");
    a_evt_limit: assert property (evt[3] <= ctoe_pkg::EVT_MAX)
        else $error("event timer above limit");
    a_sync_no_send: assert property (sync_pulse && !rtr_valid
        && ttype[2] == ctoe_pkg::TT_RTR_SYNC && !pend[2] |=> !pend[2])
        else $error("sync sent a latched object");

    c_frame_sent: cover property (tx_valid && tx_ready);
    c_rtr_send: cover property (rtr_valid && trig[1] ##[1:20] push);
    c_fifo_full: cover property (!fifo_ready);
    c_sync_send: cover property (sync_pulse && trig[0]);
endmodule
`default_nettype wire

// file: ctoe_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
// far end controller: takes frames at a pace the bench picks
module ctoe_bus_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] pace,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [10:0] tx_id,
    input wire logic [3:0] tx_dlc,
    input wire logic [63:0] tx_data,
    output logic rx_stb,
    output logic [78:0] rx_frame
);
    logic [1:0] div;
    // divider for the slow pace
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            div <= 2'h0;
        else
            div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    end
    // 0 stalls, 1 takes every cycle, 2 every third cycle
    assign tx_ready = (pace == 2'h1) || (pace == 2'h2 && div == 2'h0);
    // frame taken; a data field over eight bytes is dropped
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_stb <= 1'b0;
            rx_frame <= '0;
        end
        else
        begin
            rx_stb <= tx_valid && tx_ready && tx_dlc <= 4'h8;
            rx_frame <= {tx_id, tx_dlc, tx_data};
        end
    end
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int EVT = 20;
    localparam int INH = 5;
    logic sys_clk, rst_n, nmt, syn, rtv, reg_wr, reg_rd, tx_valid, tx_ready;
    logic rx_stb;
    logic [1:0] pace;
    logic [3:0] tx_dlc;
    logic [6:0] node;
    logic [8:0] addr;
    logic [10:0] rtr_id, tx_id;
    logic [31:0] wdata, reg_rdata, rv;
    logic [63:0] tx_data;
    logic [78:0] rx_frame;
    logic [255:0] words, w0;
    logic [78:0] got_q[$];
    int t_q[$];
    int fails, compares, cyc, seed, g;
    int mid[4], mcnt[4], midx[4][4], mlen[4][4];

    ctoe_engine #(.EVT_CYC(EVT), .INH_CYC(INH)) ctoe_engine_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .node_id(node),
        .nmt_operational(nmt), .sync_pulse(syn), .rtr_valid(rtv),
        .rtr_id(rtr_id), .output_word_marker(words), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data));
    ctoe_bus_model ctoe_bus_model_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .pace(pace),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
        .tx_dlc(tx_dlc), .tx_data(tx_data), .rx_stb(rx_stb),
        .rx_frame(rx_frame));

    // clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // cycle count, frame capture, hang limit
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (rx_stb)
        begin
            got_q.push_back(rx_frame);
            t_q.push_back(cyc);
        end
        if (cyc == 30000)
        begin
            fails++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [78:0] got, input logic [78:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int o, input int s, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        addr <= 9'(o * 64 + s * 4);
        wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic rc(input int o, input int s, input logic [31:0] e);
        rd(9'(o * 64 + s * 4));
        chk(79'(rv), 79'(e));
    endtask
    task automatic mapw(input int o, input int j, input logic [15:0] x,
        input int n);
        wr(o, 5 + j, {x, 8'h00, 8'(n)});
        midx[o][j] = x;
        mlen[o][j] = n;
    endtask
    task automatic rnd_words();
        @(posedge sys_clk);
        for (int k = 0; k < 8; k++)
            words[k * 32 +: 32] <= $random(seed);
    endtask
    task automatic pulse_sync(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            syn <= 1'b1;
            @(posedge sys_clk);
            syn <= 1'b0;
            repeat (8) @(posedge sys_clk);
        end
    endtask
    task automatic rtr(input logic [10:0] id);
        @(posedge sys_clk);
        rtv <= 1'b1;
        rtr_id <= id;
        @(posedge sys_clk);
        rtv <= 1'b0;
    endtask
    // expected frame of object o from the bench map
    function automatic logic [78:0] expf(input int o, input logic [255:0] w);
        logic [63:0] d;
        logic [15:0] v;
        int p;
        d = '0;
        p = 0;
        for (int j = 0; j < mcnt[o]; j++)
        begin
            v = (midx[o][j] >= 16'h3D22 && midx[o][j] <= 16'h3D31) ?
                w[(midx[o][j] - 16'h3D22) * 16 +: 16] : 16'h0000;
            if (mlen[o][j] == 8)
                v = v & 16'h00FF;
            d = d | (64'(v) << p);
            p = p + mlen[o][j];
        end
        return {11'(mid[o]), 4'(p / 8), d};
    endfunction
    // waits for n frames of object o, then checks count and contents
    task automatic take(input int o, input int n, input logic [255:0] w,
        output int gap);
        for (int i = 0; i < 300 && got_q.size() < n; i++)
            @(posedge sys_clk);
        repeat (30) @(posedge sys_clk);
        chk(79'(got_q.size()), 79'(n));
        gap = (t_q.size() > 1) ? t_q[1] - t_q[0] : 0;
        foreach (got_q[i])
            chk(got_q[i], expf(o, w));
        got_q.delete();
        t_q.delete();
    endtask

    // main sequence
    initial
    begin
        seed = 99;
        fails = 0;
        compares = 0;
        cyc = 0;
        rst_n = 1'b0;
        nmt = 1'b0;
        syn = 1'b0;
        rtv = 1'b0;
        rtr_id = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        addr = '0;
        wdata = '0;
        pace = 2'h1;
        words = '0;
        node = 7'($random(seed));
        for (int o = 0; o < 4; o++)
        begin
            mid[o] = ctoe_pkg::ID_BASE[o] + node;
            mcnt[o] = 4;
            for (int j = 0; j < 4; j++)
            begin
                midx[o][j] = 16'h3D22 + 4 * o + j;
                mlen[o][j] = 16;
            end
        end
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int o = 0; o < 4; o++)
        begin
            rc(o, 0, 32'(mid[o]));
            rc(o, 1, 32'h000000FE);
            rc(o, 3, 32'h00000000);
            rc(o, 4, 32'h00000004);
            for (int j = 0; j < 4; j++)
                rc(o, 5 + j, {16'(midx[o][j]), 16'h0010});
        end
        rc(7, 15, 32'h00000000);
        $display("test defaults done");
        rnd_words();
        wr(0, 0, 32'h00000123);
        mid[0] = 32'h00000123;
        wr(0, 1, 32'h00000002);
        wr(1, 1, 32'h00000000);
        pulse_sync(4);
        take(0, 0, words, g);
        nmt <= 1'b1;
        pulse_sync(4);
        take(0, 2, words, g);
        $display("test sync done");
        wr(0, 1, 32'h00000000);
        wr(1, 1, 32'h000000FD);
        rtr(11'(mid[1]));
        take(1, 1, words, g);
        rtr(11'h7FF);
        take(1, 0, words, g);
        wr(2, 1, 32'h000000FC);
        pulse_sync(1);
        w0 = words;
        rnd_words();
        rtr(11'(mid[2]));
        take(2, 1, w0, g);
        $display("test remote done");
        wr(1, 5, 32'h3D250008);
        rc(1, 5, {16'(midx[1][0]), 16'h0010});
        wr(1, 4, 32'h00000000);
        wr(1, 4, 32'h00000005);
        rc(1, 4, 32'h00000000);
        mapw(1, 0, 16'h3D25, 8);
        mapw(1, 1, 16'h3D30, 16);
        mapw(1, 2, 16'h3D22, 8);
        wr(1, 4, 32'h00000003);
        mcnt[1] = 3;
        rtr(11'(mid[1]));
        take(1, 1, words, g);
        wr(1, 4, 32'h00000000);
        rtr(11'(mid[1]));
        take(1, 0, words, g);
        $display("test remap done");
        wr(3, 3, 32'h00000003);
        take(3, 2, words, g);
        chk(79'(g), 79'(3 * EVT));
        wr(3, 3, 32'h00000CCD);
        rc(3, 3, 32'h00000003);
        wr(3, 3, 32'h00000000);
        wr(3, 1, 32'h000000FF);
        wr(3, 2, 32'h0000000A);
        wr(3, 3, 32'h00000001);
        take(3, 2, words, g);
        chk(79'(g >= 10 * INH && g <= 80), 79'(1));
        wr(3, 3, 32'h00000000);
        repeat (80) @(posedge sys_clk);
        got_q.delete();
        t_q.delete();
        $display("test timers done");
        wr(1, 4, 32'h00000003);
        wr(1, 0, 32'hFFFFF800 | mid[1]);
        rc(1, 0, 32'h80000000 | mid[1]);
        rtr(11'(mid[1]));
        take(1, 0, words, g);
        wr(2, 1, 32'h000000F1);
        pulse_sync(1);
        rtr(11'(mid[2]));
        take(2, 0, words, g);
        $display("test disable done");
        pace <= 2'h0;
        wr(0, 1, 32'h00000001);
        pulse_sync(10);
        rd(ctoe_pkg::STATUS_ADDR);
        chk(79'(rv[3:0]), 79'(8));
        pace <= 2'h2;
        take(0, 9, words, g);
        wr(0, 1, 32'h00000000);
        rd(ctoe_pkg::STATUS_ADDR);
        chk(79'(rv[3:0]), 79'(0));
        $display("test buffer done");
        stop_test();
    end
endmodule
`default_nettype wire
